// file: hdl/ctxb_pkg.sv
// Package for the CAN transmit-buffer configuration block.
// Assumes one 100 MHz clock and a 32-bit AHB-Lite register bus.
package ctxb_pkg;
  localparam logic [7:0] TXBC_OFFSET = 8'hc0;
  localparam logic [7:0] CANCEL_IE_OFFSET = 8'he4;
  localparam logic [7:0] EVF_CFG_OFFSET = 8'hf0;
  localparam logic [7:0] EVF_STATE_OFFSET = 8'hf4;
  localparam logic [7:0] EVF_ACK_OFFSET = 8'hf8;
  localparam logic [7:0] CTRL_OFFSET = 8'h18;
  localparam logic [7:0] LAYOUT_OFFSET = 8'h1c;

  localparam int MODE_POS = 30;
  localparam int SHARED_LSB = 24;
  localparam int DEDIC_LSB = 16;
  localparam int START_LSB = 2;
  localparam int START_W = 14;
  localparam int CNT_W = 6;
  localparam logic [5:0] CNT_MAX = 6'h20;
  localparam int CTRL_INIT_POS = 0;
  localparam int CTRL_CCE_POS = 1;

  localparam logic [31:0] TXBC_RESET = 32'h00000000;
  localparam logic [31:0] TXBC_MASK = 32'h7f3ffffc;
  localparam logic [31:0] EVF_CFG_MASK = 32'h3f3ffffc;
  localparam logic [31:0] EVF_ACK_MASK = 32'h0000001f;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic shared_tx_mode_select;
    logic [5:0] shared_tx_buffer_count;
    logic [5:0] dedicated_tx_buffer_count;
    logic [13:0] tx_region_start_addr;
  } ctxb_layout_t;
endpackage : ctxb_pkg

// file: hdl/ctxb_clamp.sv
// Clamps a six-bit buffer count to its usable range.
// Pure combinational; used twice by the register block.
module ctxb_clamp (
  input wire logic [5:0] raw,
  output logic [5:0] eff
);
  import ctxb_pkg::*;
  always_comb begin
    eff = (raw > CNT_MAX) ? CNT_MAX : raw;
  end
endmodule : ctxb_clamp

// file: hdl/ctxb_regs.sv
// Transmit-buffer configuration registers behind an AHB-Lite slave.
// Assumes one clock SYS_CLK, synchronous active-low RST_N, single word transfers.
//
// Register access over AHB-Lite was decided locally.
module ctxb_regs (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [31:0] EVENT_FIFO_STATE,
  output ctxb_pkg::ctxb_layout_t LAYOUT,
  output logic [5:0] DEDICATED_EFF,
  output logic [5:0] SHARED_EFF,
  output logic [13:0] SHARED_BASE_WORD,
  output logic CONFIG_OPEN
);
  import ctxb_pkg::*;

  typedef struct packed {
    logic wr_pend;
    logic [7:0] addr;
    logic [31:0] txbc;
    // Clamped counts and shared base sit in flops beside the raw fields,
    // so every layout output moves on the same edge as the register.
    logic [5:0] ded_eff;
    logic [5:0] shr_eff;
    logic [13:0] shr_base;
    logic [31:0] cancel_ie;
    logic [31:0] evf_cfg;
    logic [31:0] evf_ack;
    logic [31:0] ctrl;
    logic [31:0] rdata;
  } ctxb_state_t;

  ctxb_state_t state_reg;
  ctxb_state_t state_next;
  logic [5:0] ded_clamped;
  logic [5:0] shr_clamped;
  logic open_w;
  logic take;

  ctxb_clamp u_ded (
    .raw(HWDATA[DEDIC_LSB +: CNT_W]),
    .eff(ded_clamped)
  );
  ctxb_clamp u_shr (
    .raw(HWDATA[SHARED_LSB +: CNT_W]),
    .eff(shr_clamped)
  );

  // Only the lowest 256 bytes decode; above that reads give zero and writes drop
  function automatic logic in_window(input logic [31:0] a);
    return a[31:8] == 24'h000000;
  endfunction : in_window

  // Word-aligned offset; the byte lanes are ignored since only whole words move
  function automatic logic [7:0] word_offset(input logic [31:0] a);
    return {a[7:2], 2'h0};
  endfunction : word_offset

  assign take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  assign open_w = state_reg.ctrl[CTRL_CCE_POS] && state_reg.ctrl[CTRL_INIT_POS];

  function automatic logic [31:0] read_mux(input ctxb_state_t s, input logic [7:0] a,
                                          input logic [31:0] evs, input logic [31:0] lay);
    case (a)
      TXBC_OFFSET: read_mux = s.txbc;
      CANCEL_IE_OFFSET: read_mux = s.cancel_ie;
      EVF_CFG_OFFSET: read_mux = s.evf_cfg;
      EVF_STATE_OFFSET: read_mux = evs;
      EVF_ACK_OFFSET: read_mux = s.evf_ack;
      CTRL_OFFSET: read_mux = s.ctrl;
      LAYOUT_OFFSET: read_mux = lay;
      default: read_mux = 32'h00000000;
    endcase
  endfunction : read_mux

  always_comb begin
    state_next = state_reg;
    if (state_reg.wr_pend) begin
      state_next.wr_pend = 1'b0;
      case (state_reg.addr)
        TXBC_OFFSET: begin
          if (open_w) begin
            state_next.txbc = HWDATA & TXBC_MASK;
            state_next.ded_eff = ded_clamped;
            state_next.shr_eff = shr_clamped;
            state_next.shr_base = HWDATA[START_LSB +: START_W] + {8'h00, ded_clamped};
          end
        end
        CANCEL_IE_OFFSET: state_next.cancel_ie = HWDATA;
        EVF_CFG_OFFSET: begin
          if (open_w) begin
            state_next.evf_cfg = HWDATA & EVF_CFG_MASK;
          end
        end
        EVF_ACK_OFFSET: state_next.evf_ack = HWDATA & EVF_ACK_MASK;
        CTRL_OFFSET: state_next.ctrl = {30'h0, HWDATA[1:0]};
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end
    if (take) begin
      state_next.addr = word_offset(HADDR);
      state_next.wr_pend = HWRITE && in_window(HADDR);
      // A write still in its data phase is forwarded, so a read right behind it sees the new value
      state_next.rdata = in_window(HADDR) ?
        read_mux(state_next, word_offset(HADDR), EVENT_FIFO_STATE, {26'h0, state_next.shr_eff}) :
        32'h00000000;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state_reg <= '0;
      state_reg.txbc <= TXBC_RESET;
      state_reg.ctrl <= CTRL_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign HRDATA = state_reg.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign CONFIG_OPEN = open_w;
  assign LAYOUT.shared_tx_mode_select = state_reg.txbc[MODE_POS];
  assign LAYOUT.shared_tx_buffer_count = state_reg.txbc[SHARED_LSB +: CNT_W];
  assign LAYOUT.dedicated_tx_buffer_count = state_reg.txbc[DEDIC_LSB +: CNT_W];
  assign LAYOUT.tx_region_start_addr = state_reg.txbc[START_LSB +: START_W];
  assign SHARED_EFF = state_reg.shr_eff;
  assign DEDICATED_EFF = state_reg.ded_eff;
  assign SHARED_BASE_WORD = state_reg.shr_base;
endmodule : ctxb_regs

// file: tb/ctxb_evf_model.sv
// Stand-in for the event FIFO status source.
// Assumes it is sampled on the block clock; pattern changes every cycle.
module ctxb_evf_model (
  input wire logic clk,
  output logic [31:0] state
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_reg = 32'h0;
  always @(posedge clk) cnt_reg <= cnt_reg + 32'h01030507;
  assign state = cnt_reg;
endmodule : ctxb_evf_model

// file: tb/ctxb_regs_properties.sv
// Assertions on the transmit-buffer configuration block.
// Assumes a bind to ctxb_regs with single word transfers.
module ctxb_chk (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire ctxb_pkg::ctxb_layout_t LAYOUT,
  input wire logic [5:0] DEDICATED_EFF,
  input wire logic [5:0] SHARED_EFF,
  input wire logic [13:0] SHARED_BASE_WORD,
  input wire logic CONFIG_OPEN
);
  import ctxb_pkg::*;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RST_N);
  wire logic c0 = HSEL && HREADY && HTRANS == HTRANS_NONSEQ && HADDR[7:0] == TXBC_OFFSET;
  wire logic [5:0] sh = LAYOUT.shared_tx_buffer_count;
  wire logic [5:0] dd = LAYOUT.dedicated_tx_buffer_count;
  AST_LOCK: assert property (!$stable(LAYOUT) |-> $past(CONFIG_OPEN)) else $error("locked");
  AST_RAW: assert property (c0 && HWRITE && CONFIG_OPEN ##1 CONFIG_OPEN |=>
    LAYOUT == {$past(HWDATA[30:24]), $past(HWDATA[21:2])}) else $error("raw");
  AST_MODE0: assert property ($rose(RST_N) |-> !LAYOUT.shared_tx_mode_select) else $error("mode");
  AST_SH: assert property (SHARED_EFF == (sh > CNT_MAX ? CNT_MAX : sh)) else $error("shared");
  AST_DD: assert property (DEDICATED_EFF == (dd > CNT_MAX ? CNT_MAX : dd)) else $error("dedic");
  AST_BASE: assert property (SHARED_BASE_WORD == LAYOUT.tx_region_start_addr + 14'(DEDICATED_EFF))
    else $error("base");
  AST_LOW: assert property (c0 && !HWRITE |=> HRDATA[1:0] == 2'h0) else $error("low");
endmodule : ctxb_chk

bind ctxb_regs ctxb_chk ctxb_chk_i (.SYS_CLK, .RST_N, .HSEL, .HADDR, .HTRANS, .HWRITE, .HWDATA, .HREADY,
  .HRDATA, .LAYOUT, .DEDICATED_EFF, .SHARED_EFF, .SHARED_BASE_WORD, .CONFIG_OPEN);

// file: tb/can_tx_buffer_config_tb.sv
// Self-checking bench for the transmit-buffer configuration block.
// Assumes the slave may stall; each wait is cut by the cycle ceiling.
module can_tx_buffer_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ctxb_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, hw = 1'b0, ry, rs, cfg;
  logic [1:0] htr = 2'h0;
  logic [31:0] ha = 32'h0, hd = 32'h0, rd, evs, q, d, ev;
  logic [31:0] lk [3] = '{32'h1, 32'h2, 32'h0};
  logic [5:0] de, se;
  logic [13:0] sb;
  ctxb_layout_t lay;
  int miscompares = 0, comparisons = 0, cyc = 0;
  always #5 clk = ~clk;
  ctxb_regs ctxb_regs_i (.SYS_CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(ha), .HTRANS(htr), .HWRITE(hw),
    .HSIZE(3'h2), .HWDATA(hd), .HREADY(ry), .HRDATA(rd), .HREADYOUT(ry), .HRESP(rs), .EVENT_FIFO_STATE(evs),
    .LAYOUT(lay), .DEDICATED_EFF(de), .SHARED_EFF(se), .SHARED_BASE_WORD(sb), .CONFIG_OPEN(cfg));
  ctxb_evf_model ctxb_evf_model_i (.clk(clk), .state(evs));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    htr <= HTRANS_NONSEQ;
    hw <= w;
    ha <= {24'h0, a};
    do @(posedge clk); while (ry !== 1'b1);
    // Status word as the slave sampled it at the address-phase edge
    ev = evs;
    htr <= 2'h0;
    hd <= wd;
    do @(posedge clk); while (ry !== 1'b1);
    q = rd;
    chk("resp", rs, 32'h0);
  endtask : bus
  function automatic logic [5:0] cl(input logic [5:0] v);
    return v > CNT_MAX ? CNT_MAX : v;
  endfunction : cl
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  initial begin
    void'($urandom(32'h4499));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, TXBC_OFFSET, 32'h0);
    chk("reset", q, TXBC_RESET);
    bus(1'b1, CTRL_OFFSET, 32'h3);
    for (int i = 0; i < 12; i++) begin
      d = $urandom;
      // first four passes: counts at or past the limit, sums far above it; then counts whose sum fits in it
      if (i < 4) begin
        d[29:16] = {6'h20 + 6'(i), 2'h0, 6'h3f - 6'(i)};
      end else begin
        d[29:24] = 6'($urandom_range(32, 0));
        d[21:16] = 6'($urandom_range(32 - int'(d[29:24]), 0));
      end
      bus(1'b1, TXBC_OFFSET, d);
      bus(1'b0, TXBC_OFFSET, 32'h0);
      chk("cfg", q, d & TXBC_MASK);
      chk("mode", lay.shared_tx_mode_select, d[30]);
      chk("shared", se, cl(d[29:24]));
      chk("dedic", de, cl(d[21:16]));
      chk("base", sb, 14'(d[15:2] + cl(d[21:16])));
      chk("open", cfg, 32'h1);
      bus(1'b0, LAYOUT_OFFSET, 32'h0);
      chk("layout", q, {26'h0, cl(d[29:24])});
    end
    foreach (lk[j]) begin
      bus(1'b1, CTRL_OFFSET, lk[j]);
      bus(1'b1, TXBC_OFFSET, ~d);
      bus(1'b0, TXBC_OFFSET, 32'h0);
      chk("closed", q, d & TXBC_MASK);
      chk("shut", cfg, 32'h0);
    end
    bus(1'b0, EVF_STATE_OFFSET, 32'h0);
    chk("evstate", q, ev);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", q, 32'h0);
    conclude();
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      conclude();
    end
  end
endmodule : can_tx_buffer_config_tb
